// file: rtl/eptb_ctrl.sv
// eptb_ctrl.sv: protection, security and timebase control for the eeprom array
// assumes one 25 MHz clock, synchronous inputs, nonvolatile cells kept by nv_por_n
// What this block does
// - set protect bit blocks program and erase
// - four bits cover four 128-byte ranges
// - security allows byte ops, locks 06F0-06FF
// - reset copies config byte into live register
// - config byte written through latch procedure
// - config byte leaves factory as F0
// - 11-bit divisor makes 35 us tick
// - reset reloads divisor from shadow bytes
// - divisor lock freezes divisor and shadows
// - divisor writable only unlatched and unlocked
// - shadow bytes guarded by security bit
// - shadow lock bit zero locks forever
// - wait mode leaves sequence running
// - stop holds sequence, resumes after exit
// - stop without latch cuts sequence
// - erase select picks operation kind
// - program enable needs latch and address
`include "eptb_params.svh"
module eptb_ctrl
	import eptb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic nv_por_n,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic ref_sel_crystal,
	input wire logic crystal_reference_clock_en,
	input wire logic stop_mode,
	output eptb_op_t array_op,
	output logic array_commit,
	output logic array_hv_on,
	output logic array_access_block,
	output logic array_power_off,
	output logic timebase_tick
);
	// nonvolatile bytes, live copies and control state
	logic [7:0] nv_cfg_q;
	logic [7:0] nv_divh_q;
	logic [7:0] nv_divl_q;
	logic [7:0] acr_q;
	logic reload_q;
	logic divsecd_q;
	logic [10:0] div_q;
	logic pgm_q;
	logic auto_q;
	logic lat_q;
	logic ers_hi_q;
	logic ers_lo_q;
	logic off_q;
	logic spare_q;
	logic lat_valid_q;
	logic [15:0] lat_addr_q;
	logic [7:0] lat_data_q;
	eptb_state_t state_q;
	logic [11:0] tick_cnt_q;
	logic [10:0] div_cnt_q;
	logic done_q;
	logic refused_q;
	logic commit_q;
	eptb_op_t op_q;
	logic [7:0] rdata_q;
	logic [11:0] target;
	logic ref_en;
	logic tick;
	logic wr_ctrl;
	logic wr_div_ok;
	logic in_array;
	logic nv_addr;
	logic latch_wr;
	logic pgm_set_req;
	logic op_ok;
	logic start;
	logic refuse;
	logic fin;
	eptb_mode_t mode_cur;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// register port decode
	assign wr_ctrl = bus_wr && bus_addr == `EPTB_OFS_CTRL;
	assign in_array = bus_addr >= `EPTB_ARR_LO && bus_addr <= `EPTB_ARR_HI;
	assign nv_addr = bus_addr == `EPTB_OFS_NVCFG || bus_addr == `EPTB_OFS_DIVHNV
		|| bus_addr == `EPTB_OFS_DIVLNV;
	assign mode_cur = eptb_mode_t'({ers_hi_q, ers_lo_q});
	// a valid array or nonvolatile write is captured while latched
	assign latch_wr = bus_wr && lat_q && !pgm_q && (in_array || nv_addr);
	assign wr_div_ok = !lat_q && divsecd_q && !reload_q;

	// operation check on the latched address and selected mode
	function automatic logic allowed(input logic [15:0] a, input eptb_mode_t m,
		input logic [7:0] acr, input logic secd);
		logic byte_op;
		logic secdis;
		byte_op = m == EPTB_BYTE_PGM || m == EPTB_BYTE_ERS;
		secdis = acr[`EPTB_ACR_SECDIS];
		allowed = 1'b1;
		if (a == `EPTB_OFS_NVCFG) begin
			allowed = byte_op;
		end else if (a == `EPTB_OFS_DIVHNV || a == `EPTB_OFS_DIVLNV) begin
			allowed = byte_op && secd;
		end else begin
			if (acr[a[8:7]]) begin
				allowed = 1'b0;
			end
			if (m == EPTB_BULK_ERS && acr[3:0] != 4'h0) begin
				allowed = 1'b0;
			end
			if (!secdis && (!byte_op || (a >= `EPTB_SEC_LO && a <= `EPTB_SEC_HI))) begin
				allowed = 1'b0;
			end
		end
	endfunction

	// start and refusal of the program enable bit
	assign op_ok = allowed(lat_addr_q, mode_cur, acr_q, divsecd_q);
	assign pgm_set_req = wr_ctrl && bus_wdata[`EPTB_CTRL_PGM] && !pgm_q;
	assign start = pgm_set_req && lat_q && lat_valid_q && op_ok && !off_q
		&& !stop_mode && state_q == ST_IDLE;
	assign refuse = pgm_set_req && !start;

	// operation length in ticks by mode
	always_comb begin
		case (op_q.mode)
			EPTB_BYTE_PGM: target = 12'(`EPTB_TICKS(`EPTB_T_PGM_US));
			EPTB_BYTE_ERS: target = 12'(`EPTB_TICKS(`EPTB_T_BYTE_US));
			EPTB_BLOCK_ERS: target = 12'(`EPTB_TICKS(`EPTB_T_BLOCK_US));
			default: target = 12'(`EPTB_TICKS(`EPTB_T_BULK_US));
		endcase
	end
	assign fin = state_q == ST_RUN && !stop_mode && pgm_q && tick
		&& tick_cnt_q == target - 12'd1;

	// nonvolatile bytes: kept over system reset, changed only by a finished operation
	always_ff @(posedge clk or negedge nv_por_n) begin
		if (!nv_por_n) begin
			nv_cfg_q <= `EPTB_NVCFG_FACTORY;
			nv_divh_q <= `EPTB_DIVH_FACTORY;
			nv_divl_q <= `EPTB_DIVL_FACTORY;
		end else if (fin) begin
			if (op_q.addr == `EPTB_OFS_NVCFG) begin
				nv_cfg_q <= op_q.mode == EPTB_BYTE_PGM ? nv_cfg_q & op_q.data : 8'hFF;
			end
			if (op_q.addr == `EPTB_OFS_DIVHNV) begin
				nv_divh_q <= op_q.mode == EPTB_BYTE_PGM ? nv_divh_q & op_q.data : 8'hFF;
			end
			if (op_q.addr == `EPTB_OFS_DIVLNV) begin
				nv_divl_q <= op_q.mode == EPTB_BYTE_PGM ? nv_divl_q & op_q.data : 8'hFF;
			end
		end
	end

	// reload marker: one cycle after reset release the live copies are loaded
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reload_q <= 1'b1;
		end else begin
			reload_q <= 1'b0;
		end
	end

	// live configuration, read-only to software
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acr_q <= 8'h00;
		end else if (reload_q) begin
			acr_q <= nv_cfg_q;
		end
	end

	// live divisor and its lock bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			divsecd_q <= 1'b0;
			div_q <= 11'h000;
		end else if (reload_q) begin
			divsecd_q <= nv_divh_q[`EPTB_DIVH_SECD];
			div_q <= {nv_divh_q[2:0], nv_divl_q};
		end else if (bus_wr && wr_div_ok) begin
			if (bus_addr == `EPTB_OFS_DIVH) begin
				divsecd_q <= bus_wdata[`EPTB_DIVH_SECD];
				div_q[10:8] <= bus_wdata[2:0];
			end
			if (bus_addr == `EPTB_OFS_DIVL) begin
				div_q[7:0] <= bus_wdata;
			end
		end
	end

	// timebase divider on the selected reference
	assign ref_en = ref_sel_crystal ? crystal_reference_clock_en : 1'b1;
	assign tick = ref_en && div_q != 11'h000 && div_cnt_q == div_q - 11'd1;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q <= 11'h000;
		end else if (ref_en) begin
			div_cnt_q <= tick || div_cnt_q >= div_q ? 11'h000 : div_cnt_q + 11'd1;
		end
	end
	assign timebase_tick = tick;

	// control register bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pgm_q <= 1'b0;
			auto_q <= 1'b0;
			lat_q <= 1'b0;
			ers_hi_q <= 1'b0;
			ers_lo_q <= 1'b0;
			off_q <= 1'b0;
			spare_q <= 1'b0;
		end else if (fin && auto_q) begin
			pgm_q <= 1'b0; // automatic end of the cycle
		end else if (wr_ctrl && !reload_q) begin
			pgm_q <= bus_wdata[`EPTB_CTRL_PGM] ? pgm_q | start : 1'b0;
			lat_q <= bus_wdata[`EPTB_CTRL_LAT] | pgm_q; // latch held while enabled
			auto_q <= bus_wdata[`EPTB_CTRL_AUTO];
			ers_hi_q <= bus_wdata[`EPTB_CTRL_ERS_HI];
			ers_lo_q <= bus_wdata[`EPTB_CTRL_ERS_LO];
			off_q <= bus_wdata[`EPTB_CTRL_OFF];
			spare_q <= bus_wdata[`EPTB_CTRL_SPARE];
		end
	end

	// latched address and data of the last valid write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lat_valid_q <= 1'b0;
			lat_addr_q <= 16'h0000;
			lat_data_q <= 8'h00;
		end else if (!lat_q) begin
			lat_valid_q <= 1'b0;
		end else if (latch_wr) begin
			lat_valid_q <= 1'b1;
			lat_addr_q <= bus_addr;
			lat_data_q <= bus_wdata;
		end
	end

	// program/erase sequencer; wait mode has no input here, so it runs on
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			tick_cnt_q <= 12'h000;
			op_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_RUN;
						tick_cnt_q <= 12'h000;
						op_q <= '{addr: lat_addr_q, data: lat_data_q, mode: mode_cur};
					end
				end
				ST_RUN: begin
					if (stop_mode) begin
						state_q <= ST_HOLD;
					end else if (!pgm_q) begin
						state_q <= ST_IDLE;
					end else if (fin) begin
						state_q <= ST_DONE;
					end else if (tick) begin
						tick_cnt_q <= tick_cnt_q + 12'd1;
					end
				end
				ST_HOLD: begin
					if (!(lat_q && pgm_q)) begin
						state_q <= ST_IDLE;
					end else if (!stop_mode) begin
						state_q <= ST_RUN;
					end
				end
				ST_DONE: begin
					if (!pgm_q || (stop_mode && !lat_q)) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// completion pulse and status flags; a set wins over a clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			commit_q <= 1'b0;
			done_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			commit_q <= fin;
			if (fin) begin
				done_q <= 1'b1;
			end else if (start) begin
				done_q <= 1'b0;
			end
			if (refuse) begin
				refused_q <= 1'b1;
			end else if (bus_rd && bus_addr == `EPTB_OFS_STAT) begin
				refused_q <= 1'b0;
			end
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (!bus_rd) begin
			rdata_q <= 8'h00;
		end else begin
			case (bus_addr)
				`EPTB_OFS_CTRL: rdata_q <= {spare_q, off_q, ers_hi_q, ers_lo_q, 1'b0,
					lat_q, auto_q, pgm_q};
				`EPTB_OFS_STAT: rdata_q <= {3'b000, state_q == ST_HOLD, refused_q,
					lat_valid_q, done_q, state_q != ST_IDLE};
				`EPTB_OFS_ACR: rdata_q <= acr_q;
				`EPTB_OFS_NVCFG: rdata_q <= nv_cfg_q;
				`EPTB_OFS_DIVH: rdata_q <= {divsecd_q, 4'h0, div_q[10:8]};
				`EPTB_OFS_DIVL: rdata_q <= div_q[7:0];
				`EPTB_OFS_DIVHNV: rdata_q <= nv_divh_q;
				`EPTB_OFS_DIVLNV: rdata_q <= nv_divl_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// outputs toward the array
	assign bus_rdata = rdata_q;
	assign array_op = op_q;
	assign array_commit = commit_q;
	assign array_hv_on = state_q == ST_RUN;
	assign array_access_block = state_q != ST_IDLE;
	assign array_power_off = off_q;

	// checks next to the logic
	protect_block_a: assert property (
		array_hv_on && op_q.addr >= `EPTB_ARR_LO && op_q.addr <= `EPTB_ARR_HI
		|-> !acr_q[op_q.addr[8:7]])
		else $error("operation running on a protected block");
	secure_range_a: assert property (
		array_hv_on && !acr_q[`EPTB_ACR_SECDIS]
		|-> !(op_q.addr >= `EPTB_SEC_LO && op_q.addr <= `EPTB_SEC_HI)
		&& (op_q.mode == EPTB_BYTE_PGM || op_q.mode == EPTB_BYTE_ERS))
		else $error("secured array accepted a forbidden operation");
	reload_cfg_a: assert property (
		reload_q |=> acr_q == $past(nv_cfg_q)
		&& div_q == {$past(nv_divh_q[2:0]), $past(nv_divl_q)})
		else $error("reset reload did not copy the nonvolatile bytes");
	div_lock_a: assert property (
		!reload_q && !divsecd_q |=> $stable(div_q) && !divsecd_q)
		else $error("locked divisor changed");
	div_latch_a: assert property (
		!reload_q && lat_q |=> $stable(div_q) && $stable(divsecd_q))
		else $error("divisor changed while latched");
	pgm_needs_latch_a: assert property (
		$rose(pgm_q) |-> $past(lat_q) && $past(lat_valid_q))
		else $error("program enable set without latch and address");
	stop_hold_a: assert property (
		state_q == ST_RUN && stop_mode |=> state_q == ST_HOLD && !array_hv_on
		&& $stable(tick_cnt_q))
		else $error("stop did not hold the sequence");
	shadow_lock_a: assert property (
		array_hv_on && (op_q.addr == `EPTB_OFS_DIVHNV || op_q.addr == `EPTB_OFS_DIVLNV)
		|-> divsecd_q)
		else $error("locked shadow byte written");
	tick_count_a: assert property (
		tick && div_q > 11'd1 |=> !tick)
		else $error("divider ticked twice in a row");
	run_cover: cover property (state_q == ST_RUN ##1 state_q == ST_DONE);
	hold_cover: cover property (state_q == ST_HOLD ##1 state_q == ST_RUN);
	refuse_cover: cover property (refuse);
endmodule

// file: rtl/eptb_params.svh
// eptb_params.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by the package and the control module, one 25 MHz clock
`ifndef EPTB_PARAMS_SVH
`define EPTB_PARAMS_SVH
// register offsets on the 16-bit register port
`define EPTB_OFS_CTRL 16'h0050
`define EPTB_OFS_STAT 16'h0051
`define EPTB_OFS_ACR 16'h0052
`define EPTB_OFS_NVCFG 16'h0053
`define EPTB_OFS_DIVH 16'h0054
`define EPTB_OFS_DIVL 16'h0055
`define EPTB_OFS_DIVHNV 16'h0056
`define EPTB_OFS_DIVLNV 16'h0057
// array window and secured range
`define EPTB_ARR_LO 16'h0600
`define EPTB_ARR_HI 16'h07FF
`define EPTB_SEC_LO 16'h06F0
`define EPTB_SEC_HI 16'h06FF
// control and configuration field positions
`define EPTB_CTRL_PGM 0
`define EPTB_CTRL_AUTO 1
`define EPTB_CTRL_LAT 2
`define EPTB_CTRL_ERS_LO 4
`define EPTB_CTRL_ERS_HI 5
`define EPTB_CTRL_OFF 6
`define EPTB_CTRL_SPARE 7
`define EPTB_ACR_SECDIS 4
`define EPTB_DIVH_SECD 7
// factory contents of the nonvolatile bytes
`define EPTB_NVCFG_FACTORY 8'hF0
`define EPTB_DIVH_FACTORY 8'h80
`define EPTB_DIVL_FACTORY 8'h00
// timebase period and operation times
`define EPTB_TICK_NS 35000
`define EPTB_T_PGM_US 70
`define EPTB_T_BYTE_US 70
`define EPTB_T_BLOCK_US 70
`define EPTB_T_BULK_US 70
// operation lengths in timebase ticks, rounded up
`define EPTB_TICKS(us) (((us) * 1000 + `EPTB_TICK_NS - 1) / `EPTB_TICK_NS)
`endif

// file: rtl/eptb_pkg.sv
// eptb_pkg.sv: types shared by the eeprom protect and timebase control
// assumes eptb_params.svh carries every number
`include "eptb_params.svh"
package eptb_pkg;
	// erase select encoding
	typedef enum logic [1:0] {
		EPTB_BYTE_PGM = 2'b00,
		EPTB_BYTE_ERS = 2'b01,
		EPTB_BLOCK_ERS = 2'b10,
		EPTB_BULK_ERS = 2'b11
	} eptb_mode_t;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HOLD,
		ST_DONE
	} eptb_state_t;
	// operation handed to the array
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		eptb_mode_t mode;
	} eptb_op_t;
endpackage

// file: verif/eptb_ctrl_tb.sv
// eptb_ctrl_tb.sv: self-checking bench for the eeprom protect and timebase control
// assumes eptb_pkg and eptb_params.svh compiled first, one 25 MHz clock
`include "eptb_params.svh"
module eptb_ctrl_tb
	import eptb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] CTRL = `EPTB_OFS_CTRL;
	localparam logic [15:0] ACR = `EPTB_OFS_ACR;
	localparam logic [15:0] NVCFG = `EPTB_OFS_NVCFG;
	localparam logic [15:0] DIVH = `EPTB_OFS_DIVH;
	localparam logic [15:0] DIVL = `EPTB_OFS_DIVL;
	logic clk, reset_n, nv_por_n, bus_wr, bus_rd, ref_sel_crystal, stop_mode;
	logic xen = 1'b0;
	logic [15:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata, rv;
	logic [1:0] xdiv = 2'd0;
	eptb_op_t array_op, op_q;
	logic array_commit, array_hv_on, array_access_block, array_power_off, timebase_tick;
	logic ok;
	int miscompares, checks, n;
	eptb_ctrl u_dut (.clk(clk), .reset_n(reset_n), .nv_por_n(nv_por_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.ref_sel_crystal(ref_sel_crystal), .crystal_reference_clock_en(xen),
		.stop_mode(stop_mode), .array_op(array_op), .array_commit(array_commit),
		.array_hv_on(array_hv_on), .array_access_block(array_access_block),
		.array_power_off(array_power_off), .timebase_tick(timebase_tick));
	// bus clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// crystal reference enable, one pulse every fourth bus cycle
	always @(posedge clk) begin
		xdiv <= xdiv + 2'd1;
		xen <= (xdiv == 2'd3);
	end
	task automatic tally_and_finish();
		if (miscompares == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask
	// read data sampled in the cycle after the strobe edge
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, exp);
	endtask
	// system reset keeps the nonvolatile bytes; divisor rewritten for the 25 MHz bus clock
	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		wr(DIVH, 8'h83);
		wr(DIVL, 8'h6B);
	endtask
	// latch, target write, auto program enable; optional stop in mid-run
	task automatic op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d,
		input bit stp);
		wr(CTRL, ctl | 8'h04);
		wr(a, d);
		wr(CTRL, ctl | 8'h07);
		@(posedge clk);
		#1 ok = array_hv_on;
		if (ok === 1'b1) begin
			if (stp) begin
				@(posedge clk);
				stop_mode <= 1'b1;
				repeat (2) @(posedge clk);
				#1 chk({array_hv_on, array_access_block}, 2'b01);
				@(posedge clk);
				stop_mode <= 1'b0;
				repeat (2) @(posedge clk);
				#1 chk(array_hv_on, 1'b1);
			end
			for (int i = 0; i < 4000 && array_commit !== 1'b1; i++) begin
				@(posedge clk);
				#1;
			end
			op_q = array_op;
			chk(array_commit, 1'b1);
			@(posedge clk);
		end else begin
			rchk(`EPTB_OFS_STAT, 8'h0C);
		end
		wr(CTRL, 8'h00);
	endtask
	// count ticks over 48 cycles from the chosen reference
	task automatic tcount(input bit sel);
		@(posedge clk);
		ref_sel_crystal <= sel;
		n = 0;
		repeat (48) begin
			@(posedge clk);
			#1 if (timebase_tick === 1'b1) n++;
		end
		@(posedge clk);
		ref_sel_crystal <= 1'b0;
	endtask
	// watchdog
	initial begin
		#2400000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		{bus_wr, bus_rd, ref_sel_crystal, stop_mode} = '0;
		bus_addr = '0;
		bus_wdata = '0;
		{miscompares, checks} = '0;
		reset_n = 1'b0;
		nv_por_n = 1'b0;
		repeat (12) @(posedge clk);
		{nv_por_n, reset_n} <= 2'b11;
		repeat (2) @(posedge clk);
		// reset contents and access kinds
		rchk(ACR, 8'hF0);
		rchk(NVCFG, 8'hF0);
		rchk(DIVH, 8'h80);
		rchk(DIVL, 8'h00);
		rchk(16'h0040, 8'h00);
		wr(ACR, 8'h00);
		rchk(ACR, 8'hF0);
		// divisor write gated by latch
		wr(DIVL, 8'h02);
		rchk(DIVL, 8'h02);
		wr(CTRL, 8'h04);
		wr(DIVL, 8'h09);
		rchk(DIVL, 8'h02);
		wr(CTRL, 8'h00);
		tcount(1'b0);
		chk(n >= 16 && n <= 24, 1'b1);
		tcount(1'b1);
		chk(n >= 4 && n <= 6, 1'b1);
		// divisor for a 35 us tick from the 25 MHz bus clock before any operation
		wr(DIVH, 8'h83);
		wr(DIVL, 8'h6B);
		// power-down bit shows on its pin and blocks a start
		wr(CTRL, 8'h40);
		#1 chk(array_power_off, 1'b1);
		wr(CTRL, 8'h00);
		#1 chk(array_power_off, 1'b0);
		op(8'h40, 16'h0700, 8'h33, 1'b0);
		chk(ok, 1'b0);
		// every mode, unprotected and unsecured; stop during byte erase
		for (int m = 0; m < 4; m++) begin
			op({2'b00, 2'(m), 4'h0}, 16'h0700 + 16'(m), 8'h5A, m == 1);
			chk(ok, 1'b1);
			chk(op_q, {16'h0700 + 16'(m), 8'h5A, 2'(m)});
		end
		// protect block 0 through the configuration byte
		op(8'h10, NVCFG, 8'h00, 1'b0);
		op(8'h00, NVCFG, 8'hF1, 1'b0);
		rchk(NVCFG, 8'hF1);
		do_reset();
		rchk(ACR, 8'hF1);
		op(8'h00, 16'h067F, 8'h11, 1'b0);
		chk(ok, 1'b0);
		op(8'h00, 16'h0680, 8'h11, 1'b0);
		chk(ok, 1'b1);
		// security enabled
		op(8'h10, NVCFG, 8'h00, 1'b0);
		op(8'h00, NVCFG, 8'hE0, 1'b0);
		do_reset();
		rchk(ACR, 8'hE0);
		op(8'h00, 16'h06F0, 8'h22, 1'b0);
		chk(ok, 1'b0);
		op(8'h20, 16'h0700, 8'h22, 1'b0);
		chk(ok, 1'b0);
		op(8'h10, 16'h0700, 8'h22, 1'b0);
		chk(ok, 1'b1);
		op(8'h00, 16'h06EF, 8'h22, 1'b0);
		chk(ok, 1'b1);
		// arm the divisor lock for good
		op(8'h00, `EPTB_OFS_DIVHNV, 8'h00, 1'b0);
		chk(ok, 1'b1);
		do_reset();
		rchk(DIVH, 8'h00);
		wr(DIVH, 8'h80);
		rchk(DIVH, 8'h00);
		rchk(DIVL, 8'h00);
		op(8'h00, `EPTB_OFS_DIVLNV, 8'h00, 1'b0);
		chk(ok, 1'b0);
		tcount(1'b0);
		chk(n, 0);
		do_reset();
		rchk(DIVH, 8'h00);
		tally_and_finish();
	end
endmodule
